/* verilog/hcbce_pkg.sv */
// shared constants of the host-side command block chain engine
package hcbce_pkg;
  // ====================================================
  // wake-up port codes
  localparam logic [7:0] WAKE_CLEAR = 8'h00;
  localparam logic [7:0] WAKE_START = 8'h01;
  localparam logic [7:0] WAKE_RESET = 8'h02;
  // ====================================================
  // host memory window, segment of the wake-up block
  localparam logic [15:0] WAKE_SEG = 16'h0100;
  localparam logic [7:0] WUB_OFF = 8'h00;
  localparam logic [7:0] CCB_OFF = 8'h10;
  localparam logic [7:0] CIB_OFF = 8'h20;
  localparam logic [7:0] PB_OFF = 8'h30;
  localparam logic [7:0] PB_LAST = 8'h4d;
  // ====================================================
  // field offsets inside the blocks
  localparam logic [7:0] WUB_CCBPTR = 8'h02;
  localparam logic [7:0] CCB_PROG = 8'h00;
  localparam logic [7:0] CCB_BUSY = 8'h01;
  localparam logic [7:0] CCB_CIBPTR = 8'h02;
  localparam logic [7:0] CCB_WORD2 = 8'h08;
  localparam logic [7:0] CCB_CPPTR = 8'h0a;
  localparam logic [7:0] CCB_CP = 8'h0e;
  localparam logic [7:0] CIB_STAT = 8'h01;
  localparam logic [7:0] CIB_SEM = 8'h03;
  localparam logic [7:0] CIB_PBPTR = 8'h08;
  localparam logic [7:0] CIB_PTR_ADJ = 8'h04;
  localparam logic [7:0] PB_ACT = 8'h04;
  localparam logic [7:0] PB_DEV = 8'h08;
  localparam logic [7:0] PB_UNIT = 8'h0a;
  localparam logic [7:0] PB_FUNC = 8'h0b;
  localparam logic [7:0] PB_MOD = 8'h0c;
  localparam logic [7:0] PB_CYL = 8'h0e;
  localparam logic [7:0] PB_HEAD = 8'h10;
  localparam logic [7:0] PB_SECT = 8'h11;
  localparam logic [7:0] PB_BUF = 8'h12;
  localparam logic [7:0] PB_REQ = 8'h16;
  // ====================================================
  // block contents
  localparam logic [7:0] SYSOP_CODE = 8'h01;
  localparam logic [7:0] PROG_ROM = 8'h01;
  localparam logic [7:0] PROG_HOST = 8'h03;
  localparam logic [7:0] BUSY_SET = 8'hff;
  localparam logic [7:0] BUSY_CLR = 8'h00;
  localparam logic [7:0] WORD2_CODE = 8'h01;
  localparam logic [15:0] CP_VAL = 16'h0004;
  localparam logic [7:0] SEM_FREE = 8'h00;
  localparam logic [7:0] SEM_POSTED = 8'hff;
  localparam logic [7:0] UNIT_MASK = 8'h03;
  localparam logic [15:0] DEV_HARD = 16'h0000;
  localparam logic [15:0] DEV_FLOP8 = 16'h0001;
  localparam logic [15:0] DEV_FLOP5 = 16'h0003;
  localparam logic [15:0] DEV_TAPE = 16'h0004;
  // ====================================================
  // software register map, byte addresses
  localparam logic [9:0] REG_CTRL = 10'h000;
  localparam logic [9:0] REG_CMD = 10'h004;
  localparam logic [9:0] REG_GEOM = 10'h008;
  localparam logic [9:0] REG_MOD = 10'h00c;
  localparam logic [9:0] REG_BUF = 10'h010;
  localparam logic [9:0] REG_REQ = 10'h014;
  localparam logic [9:0] REG_RES = 10'h018;
  localparam logic [9:0] REG_ACT = 10'h01c;
  localparam int WIN_BIT = 8;
  localparam int CTRL_INIT = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_DONE_CLR = 2;
  // countdown load; two wake-up port writes land six cycles apart
  localparam logic [2:0] PORT_GAP = 3'h4;
  localparam logic [2:0] SEQ_RET = 3'h3;

  typedef enum {S_IDLE, S_FILL, S_PORT, S_GAP, S_POLL, S_WAIT, S_READ, S_SEMCLR, S_INTCLR} hcbce_state_e;

  // segment:offset pointer, offset first, little endian
  function automatic logic [7:0] hcbce_ptr_byte(input logic [1:0] k, input logic [7:0] off);
    logic [7:0] b;
    b = 8'h00;
    case (k)
      2'h0: b = off;
      2'h2: b = WAKE_SEG[7:0];
      2'h3: b = WAKE_SEG[15:8];
      default: b = 8'h00;
    endcase
    return b;
  endfunction : hcbce_ptr_byte
endpackage : hcbce_pkg

/* verilog/hcbce_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module hcbce_sync #(parameter int W = 1) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : hcbce_sync

/* verilog/hcbce_mem.sv */
// host memory window: byte array, NP ports, higher port wins a write clash
`timescale 1ns/1ps
module hcbce_mem #(parameter int NP = 3) (
  // clock
  input wire logic clk,
  // ports
  input wire logic [NP-1:0] we,
  input wire logic [NP-1:0][7:0] addr,
  input wire logic [NP-1:0][7:0] wdata,
  output logic [NP-1:0][7:0] rdata
);
  logic [7:0] mem [0:255];
  always_ff @(posedge clk) begin
    for (int p = 0; p < NP; p++) begin
      if (we[p]) begin
        mem[addr[p]] <= wdata[p];
      end
    end
  end
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      rdata[p] = mem[addr[p]];
    end
  end
endmodule : hcbce_mem

/* verilog/hcbce_host.sv */
// host controller that builds the command block chain and drives the board
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// [RULE1] host keeps wake-up, channel and invocation blocks fixed; only parameter block moves
// [RULE2] host fills command and parameter blocks before writing start code
// [RULE3] board follows pointer chain down to parameter block before acting
// [RULE4] board reads wake-up block only on first start after reset
// [RULE5] board copies command and parameters into local memory, then runs
// [RULE6] reads stage drive data locally, then DMA into host memory
// [RULE7] board posts status, interrupts host, then idles
// [RULE8] host writes zero into every reserved block byte
// [RULE9] wake-up block sits at port selection value shifted left four bits
// [RULE10] wake-up byte 0 holds 01, bytes 2-5 channel block pointer
// [RULE11] channel byte 0: 01 on-board program, 03 host-memory program
// [RULE12] board sets busy flag FF while working, 00 when done
// [RULE13] channel and invocation addresses stay fixed until new reset
// [RULE14] channel bytes 8=01, 10-13 point to 14, 14-15 hold 0004
// [RULE15] channel bytes 2-5 point to invocation block byte four
// [RULE16] status posted only when semaphore 00; host clears FF to 00 after reading
// [RULE17] board ignores invocation byte 2
// [RULE18] invocation: byte 1 status, 4-7 zero, 8-11 parameter block pointer
// [RULE19] parameter block is 30 bytes, first four always zero
// [RULE20] board returns actual byte count little-endian in bytes 4-7
// [RULE21] device code 0000 disk, 0001 8in, 0003 5in, 0004 tape
// [RULE22] unit byte uses bits 0-1 only, rest reserved
// [RULE23] board decodes two low bits: 00 clear, 01 start, 02 reset
// [RULE24] board interrupt holds until host writes clear code
// [RULE25] board ignores start while busy
module hcbce_host
  import hcbce_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESETN,
  // software port
  input wire logic [9:0] SW_ADDR,
  input wire logic [31:0] SW_WDATA,
  input wire logic SW_WR,
  input wire logic SW_RD,
  output logic [31:0] SW_RDATA,
  // wake-up port
  output logic WAKE_WR,
  output logic [7:0] WAKE_DATA,
  // board interrupt
  input wire logic DEV_INT,
  // board bus-master access to host memory
  input wire logic MEM_REQ,
  input wire logic MEM_WE,
  input wire logic [19:0] MEM_ADDR,
  input wire logic [7:0] MEM_WDATA,
  output logic MEM_ACK,
  output logic [7:0] MEM_RDATA
);
  // ====================================================
  // synchronisers and memory
  logic int_s;
  logic req_s;
  logic we_s;
  logic [19:0] addr_s;
  logic [7:0] wd_s;
  logic [2:0] we_v;
  logic [2:0][7:0] addr_v;
  logic [2:0][7:0] wd_v;
  logic [2:0][7:0] rd_v;
  hcbce_sync #(.W(1)) u_int_sync (.clk(SYS_CLK), .resetn(RESETN), .d(DEV_INT), .q(int_s));
  hcbce_sync #(.W(30)) u_bus_sync (.clk(SYS_CLK), .resetn(RESETN),
    .d({MEM_REQ, MEM_WE, MEM_ADDR, MEM_WDATA}), .q({req_s, we_s, addr_s, wd_s}));
  hcbce_mem #(.NP(3)) u_mem (.clk(SYS_CLK), .we(we_v), .addr(addr_v), .wdata(wd_v), .rdata(rd_v));

  // ====================================================
  // state
  hcbce_state_e state, next_state;
  logic [7:0] idx, next_idx;
  logic [2:0] step, next_step;
  logic [2:0] gap, next_gap;
  logic [2:0] seq, next_seq;
  logic is_init, next_is_init;
  logic linked, next_linked;
  logic done, next_done;
  logic refused, next_refused;
  logic int_q, next_int_q;
  logic int_pend, next_int_pend;
  logic [7:0] op_status, next_op_status;
  logic [7:0] sem, next_sem;
  logic [31:0] act_cnt, next_act_cnt;
  logic [31:0] cmd, next_cmd;
  logic [31:0] geom, next_geom;
  logic [15:0] modreg, next_modreg;
  logic [7:0] bufoff, next_bufoff;
  logic [31:0] reqcnt, next_reqcnt;
  logic next_wake_wr;
  logic [7:0] next_wake_data;
  logic next_mem_ack;
  logic [7:0] next_mem_rdata;
  logic [31:0] next_sw_rdata;
  logic eng_we;
  logic [7:0] eng_addr;
  logic [7:0] eng_wdata;
  logic [7:0] fill_byte;
  logic [7:0] rel;
  logic dev_hit;
  logic in_win;
  logic sw_ctrl;
  logic dev_ok;

  // ====================================================
  // block contents, by window offset
  always_comb begin
    fill_byte = 8'h00;
    rel = 8'h00;
    case (idx)
      // [RULE10] wake-up opcode
      WUB_OFF: fill_byte = SYSOP_CODE;
      // [RULE11] on-board program
      CCB_OFF + CCB_PROG: fill_byte = PROG_ROM;
      // [RULE12] busy preset, board clears it
      CCB_OFF + CCB_BUSY: fill_byte = BUSY_SET;
      // [RULE14] fixed channel words
      CCB_OFF + CCB_WORD2: fill_byte = WORD2_CODE;
      CCB_OFF + CCB_CP: fill_byte = CP_VAL[7:0];
      CCB_OFF + CCB_CP + 8'h01: fill_byte = CP_VAL[15:8];
      // [RULE21] device code
      PB_OFF + PB_DEV: fill_byte = cmd[23:16];
      PB_OFF + PB_DEV + 8'h01: fill_byte = cmd[31:24];
      // [RULE22] reserved unit bits forced low
      PB_OFF + PB_UNIT: fill_byte = cmd[15:8] & UNIT_MASK;
      PB_OFF + PB_FUNC: fill_byte = cmd[7:0];
      PB_OFF + PB_MOD: fill_byte = modreg[7:0];
      PB_OFF + PB_MOD + 8'h01: fill_byte = modreg[15:8];
      PB_OFF + PB_CYL: fill_byte = geom[7:0];
      PB_OFF + PB_CYL + 8'h01: fill_byte = geom[15:8];
      PB_OFF + PB_HEAD: fill_byte = geom[23:16];
      PB_OFF + PB_SECT: fill_byte = geom[31:24];
      default: begin
        // [RULE8] everything not named stays zero
        fill_byte = 8'h00;
        rel = idx - (WUB_OFF + WUB_CCBPTR);
        if (rel < 8'h04) fill_byte = hcbce_ptr_byte(rel[1:0], CCB_OFF);
        // [RULE15] pointer to invocation byte four
        rel = idx - (CCB_OFF + CCB_CIBPTR);
        if (rel < 8'h04) fill_byte = hcbce_ptr_byte(rel[1:0], CIB_OFF + CIB_PTR_ADJ);
        rel = idx - (CCB_OFF + CCB_CPPTR);
        if (rel < 8'h04) fill_byte = hcbce_ptr_byte(rel[1:0], CCB_OFF + CCB_CP);
        // [RULE18] parameter block pointer
        rel = idx - (CIB_OFF + CIB_PBPTR);
        if (rel < 8'h04) fill_byte = hcbce_ptr_byte(rel[1:0], PB_OFF);
        rel = idx - (PB_OFF + PB_BUF);
        if (rel < 8'h04) fill_byte = hcbce_ptr_byte(rel[1:0], bufoff);
        rel = idx - (PB_OFF + PB_REQ);
        if (rel < 8'h04) fill_byte = reqcnt[{rel[1:0], 3'h0} +: 8];
      end
    endcase
  end

  // ====================================================
  // engine
  assign sw_ctrl = SW_WR && (SW_ADDR == REG_CTRL);
  // [RULE21] a command start goes out only with a documented device code; the init start does not check it
  assign dev_ok = (cmd[31:16] == DEV_HARD) || (cmd[31:16] == DEV_FLOP8) ||
                  (cmd[31:16] == DEV_FLOP5) || (cmd[31:16] == DEV_TAPE);

  always_comb begin
    next_state = state;
    next_idx = idx;
    next_step = step;
    next_gap = gap;
    next_seq = seq;
    next_is_init = is_init;
    next_linked = linked;
    next_refused = refused;
    next_op_status = op_status;
    next_sem = sem;
    next_act_cnt = act_cnt;
    next_wake_wr = 1'b0;
    next_wake_data = WAKE_DATA;
    next_int_q = int_s;
    // set wins over the take below
    next_int_pend = int_pend;
    next_done = done;
    if (sw_ctrl && SW_WDATA[CTRL_DONE_CLR]) next_done = 1'b0;
    eng_we = 1'b0;
    eng_addr = idx;
    eng_wdata = fill_byte;
    case (state)
      S_IDLE: begin
        if (int_pend) begin
          next_int_pend = 1'b0;
          next_step = 3'h0;
          next_state = S_READ;
        end else if (sw_ctrl && SW_WDATA[CTRL_INIT]) begin
          next_is_init = 1'b1;
          next_linked = 1'b0;
          next_idx = WUB_OFF;
          next_state = S_FILL;
        end else if (sw_ctrl && SW_WDATA[CTRL_START]) begin
          // [RULE1] a start rewrites only the parameter block
          if (linked && dev_ok) begin
            next_is_init = 1'b0;
            next_idx = PB_OFF;
            next_state = S_FILL;
          end else begin
            next_refused = 1'b1;
          end
        end
      end
      S_FILL: begin
        // [RULE19] parameter block written whole, head zeros included
        eng_we = 1'b1;
        next_idx = idx + 8'h01;
        // [RULE2] start only after the fill
        if (idx == PB_LAST) begin
          next_seq = is_init ? 3'h0 : 3'h2;
          next_state = S_PORT;
        end
      end
      S_PORT: begin
        // [RULE13] reset, clear, then start relinks the chain
        next_wake_wr = 1'b1;
        next_wake_data = (seq == 3'h0) ? WAKE_RESET : (seq == 3'h1) ? WAKE_CLEAR : WAKE_START;
        next_gap = PORT_GAP;
        next_state = S_GAP;
      end
      S_GAP: begin
        next_gap = gap - 3'h1;
        if (gap == 3'h0) begin
          if (seq < 3'h2) begin
            next_seq = seq + 3'h1;
            next_state = S_PORT;
          end else if (is_init && !linked) begin
            next_state = S_POLL;
          end else if (seq == SEQ_RET) begin
            next_state = S_IDLE;
          end else begin
            next_state = S_WAIT;
          end
        end
      end
      S_POLL: begin
        // [RULE12] cold start is over once the busy byte is cleared
        eng_addr = CCB_OFF + CCB_BUSY;
        if (int_pend) begin
          next_int_pend = 1'b0;
          next_step = 3'h0;
          next_state = S_READ;
        end else if (rd_v[1] == BUSY_CLR) begin
          next_linked = 1'b1;
          next_state = S_IDLE;
        end
      end
      S_WAIT: begin
        if (int_pend) begin
          next_int_pend = 1'b0;
          next_step = 3'h0;
          next_state = S_READ;
        end
      end
      S_READ: begin
        next_step = step + 3'h1;
        case (step)
          3'h0: begin
            eng_addr = CIB_OFF + CIB_STAT;
            next_op_status = rd_v[1];
          end
          3'h1: begin
            eng_addr = CIB_OFF + CIB_SEM;
            next_sem = rd_v[1];
          end
          default: begin
            // [RULE20] actual count, low byte first
            eng_addr = PB_OFF + PB_ACT + {5'h00, step - 3'h2};
            next_act_cnt[{step[1:0] - 2'h2, 3'h0} +: 8] = rd_v[1];
            if (step == 3'h5) next_state = S_SEMCLR;
          end
        endcase
      end
      S_SEMCLR: begin
        // [RULE16] hand the status slot back
        eng_addr = CIB_OFF + CIB_SEM;
        eng_wdata = SEM_FREE;
        eng_we = (sem == SEM_POSTED);
        next_state = S_INTCLR;
      end
      S_INTCLR: begin
        // [RULE24] drop the board interrupt
        next_wake_wr = 1'b1;
        next_wake_data = WAKE_CLEAR;
        next_done = 1'b1;
        next_seq = SEQ_RET;
        next_gap = PORT_GAP;
        next_state = S_GAP;
      end
      default: next_state = S_IDLE;
    endcase
    if (int_s && !int_q) next_int_pend = 1'b1;
    if (sw_ctrl && SW_WDATA[CTRL_INIT]) next_refused = 1'b0;
  end

  // ====================================================
  // board access to the window, four-phase handshake
  assign in_win = (addr_s[19:8] == WAKE_SEG[15:4]);
  assign dev_hit = req_s && !MEM_ACK;
  always_comb begin
    next_mem_ack = MEM_ACK;
    next_mem_rdata = MEM_RDATA;
    if (dev_hit) begin
      next_mem_ack = 1'b1;
      next_mem_rdata = in_win ? rd_v[2] : 8'h00;
    end else if (!req_s) begin
      next_mem_ack = 1'b0;
    end
  end
  assign we_v = {dev_hit && we_s && in_win, eng_we, SW_WR && SW_ADDR[WIN_BIT]};
  assign addr_v = {addr_s[7:0], eng_addr, SW_ADDR[7:0]};
  assign wd_v = {wd_s, eng_wdata, SW_WDATA[7:0]};

  // ====================================================
  // software registers
  always_comb begin
    next_cmd = cmd;
    next_geom = geom;
    next_modreg = modreg;
    next_bufoff = bufoff;
    next_reqcnt = reqcnt;
    // fields are locked while the engine runs
    if (SW_WR && state == S_IDLE) begin
      case (SW_ADDR)
        REG_CMD: next_cmd = SW_WDATA;
        REG_GEOM: next_geom = SW_WDATA;
        REG_MOD: next_modreg = SW_WDATA[15:0];
        REG_BUF: next_bufoff = SW_WDATA[7:0];
        REG_REQ: next_reqcnt = SW_WDATA;
        default: next_cmd = cmd;
      endcase
    end
    next_sw_rdata = 32'h0000_0000;
    if (SW_RD) begin
      if (SW_ADDR[WIN_BIT]) begin
        next_sw_rdata = {24'h00_0000, rd_v[0]};
      end else begin
        case (SW_ADDR)
          REG_CTRL: next_sw_rdata = {27'h000_0000, refused, int_s, done, linked, state != S_IDLE};
          REG_CMD: next_sw_rdata = cmd;
          REG_GEOM: next_sw_rdata = geom;
          REG_MOD: next_sw_rdata = {16'h0000, modreg};
          REG_BUF: next_sw_rdata = {24'h00_0000, bufoff};
          REG_REQ: next_sw_rdata = reqcnt;
          REG_RES: next_sw_rdata = {16'h0000, sem, op_status};
          REG_ACT: next_sw_rdata = act_cnt;
          default: next_sw_rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      state <= S_IDLE;
      idx <= 8'h00;
      step <= 3'h0;
      gap <= 3'h0;
      seq <= 3'h0;
      is_init <= 1'b0;
      linked <= 1'b0;
      done <= 1'b0;
      refused <= 1'b0;
      int_q <= 1'b0;
      int_pend <= 1'b0;
      op_status <= 8'h00;
      sem <= 8'h00;
      act_cnt <= 32'h0000_0000;
      cmd <= 32'h0000_0000;
      geom <= 32'h0000_0000;
      modreg <= 16'h0000;
      bufoff <= 8'h00;
      reqcnt <= 32'h0000_0000;
      WAKE_WR <= 1'b0;
      WAKE_DATA <= 8'h00;
      MEM_ACK <= 1'b0;
      MEM_RDATA <= 8'h00;
      SW_RDATA <= 32'h0000_0000;
    end else begin
      state <= next_state;
      idx <= next_idx;
      step <= next_step;
      gap <= next_gap;
      seq <= next_seq;
      is_init <= next_is_init;
      linked <= next_linked;
      done <= next_done;
      refused <= next_refused;
      int_q <= next_int_q;
      int_pend <= next_int_pend;
      op_status <= next_op_status;
      sem <= next_sem;
      act_cnt <= next_act_cnt;
      cmd <= next_cmd;
      geom <= next_geom;
      modreg <= next_modreg;
      bufoff <= next_bufoff;
      reqcnt <= next_reqcnt;
      WAKE_WR <= next_wake_wr;
      WAKE_DATA <= next_wake_data;
      MEM_ACK <= next_mem_ack;
      MEM_RDATA <= next_mem_rdata;
      SW_RDATA <= next_sw_rdata;
    end
  end

  // ====================================================
  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  sequence s_fill_end;
    state == S_FILL && idx == PB_LAST;
  endsequence
  sequence s_start_pulse;
    ##[1:40] (WAKE_WR && WAKE_DATA == WAKE_START);
  endsequence
  property p_fill_then_start;
    s_fill_end |-> s_start_pulse;
  endproperty
  a_fill_then_start: assert property (p_fill_then_start) else $error("start not issued after fill"); // RULE2
  property p_start_needs_fill;
    (WAKE_WR && WAKE_DATA == WAKE_START) |-> $past(idx) == PB_LAST + 8'h01;
  endproperty
  a_start_needs_fill: assert property (p_start_needs_fill) else $error("start without fresh block"); // RULE2
  property p_reset_clear;
    (WAKE_WR && WAKE_DATA == WAKE_RESET) |-> ##6 (WAKE_WR && WAKE_DATA == WAKE_CLEAR);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset not followed by clear"); // RULE13
  property p_wub_code;
    (eng_we && eng_addr == WUB_OFF) |-> eng_wdata == SYSOP_CODE;
  endproperty
  a_wub_code: assert property (p_wub_code) else $error("bad wake-up opcode"); // RULE10
  property p_ccb_fixed;
    (eng_we && eng_addr == CCB_OFF + CCB_WORD2) |-> eng_wdata == WORD2_CODE ##6
      (eng_we && eng_addr == CCB_OFF + CCB_CP && eng_wdata == CP_VAL[7:0]);
  endproperty
  a_ccb_fixed: assert property (p_ccb_fixed) else $error("bad channel words"); // RULE14
  property p_cib_ptr;
    (eng_we && eng_addr == CCB_OFF + CCB_CIBPTR) |-> eng_wdata == CIB_OFF + CIB_PTR_ADJ;
  endproperty
  a_cib_ptr: assert property (p_cib_ptr) else $error("bad invocation pointer"); // RULE15
  property p_pb_head_zero;
    (eng_we && eng_addr >= PB_OFF && eng_addr < PB_OFF + PB_ACT) |-> eng_wdata == 8'h00;
  endproperty
  a_pb_head_zero: assert property (p_pb_head_zero) else $error("parameter head not zero"); // RULE19
  property p_unit_bits;
    (eng_we && eng_addr == PB_OFF + PB_UNIT) |-> eng_wdata[7:2] == 6'h00;
  endproperty
  a_unit_bits: assert property (p_unit_bits) else $error("reserved unit bits set"); // RULE22
  property p_sem_release;
    (state == S_READ && step == 3'h5 && sem == SEM_POSTED) |=>
      (eng_we && eng_addr == CIB_OFF + CIB_SEM && eng_wdata == SEM_FREE) ##2 (WAKE_WR && WAKE_DATA == WAKE_CLEAR);
  endproperty
  a_sem_release: assert property (p_sem_release) else $error("semaphore not released"); // RULE16
  property p_int_clear;
    (state == S_WAIT && int_pend) |-> ##[8:9] (WAKE_WR && WAKE_DATA == WAKE_CLEAR);
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("interrupt not cleared"); // RULE24
endmodule : hcbce_host

/* dv/hcbce_board.sv */
// board model: walks the command block chain and answers the wake-up port
`timescale 1ns/1ps
module hcbce_board
  import hcbce_pkg::*;
#(parameter logic [7:0] OP_STATUS = 8'h01)
(
  // clock and wake-up port
  input wire logic clk,
  input wire logic wake_wr,
  input wire logic [7:0] wake_data,
  // interrupt and bus master
  output logic dev_int = 1'b0,
  output logic mem_req = 1'b0,
  output logic mem_we = 1'b0,
  output logic [19:0] mem_addr = '0,
  output logic [7:0] mem_wdata = '0,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata
);
  // ==========================================
  // four-phase byte cycle
  logic linked = 1'b0;
  logic [7:0] rd;
  logic [7:0] pb [30];
  logic [19:0] ccb, cib, pba, p;
  task automatic xf(input logic we, input logic [19:0] a, input logic [7:0] d);
    mem_we <= we;
    mem_addr <= a;
    mem_wdata <= d;
    mem_req <= 1'b1;
    do @(posedge clk); while (!mem_ack);
    rd = mem_rdata;
    mem_req <= 1'b0;
    // released line shows the inverse, not a stale byte
    mem_wdata <= ~d;
    do @(posedge clk); while (mem_ack);
  endtask : xf
  task automatic rptr(input logic [19:0] a, output logic [19:0] q);
    logic [7:0] b [4];
    for (int i = 0; i < 4; i++) begin
      xf(1'b0, a + 20'(i), 8'h00);
      b[i] = rd;
    end
    q = {b[3], b[2], 4'h0} + {4'h0, b[1], b[0]};
  endtask : rptr
  // ==========================================
  // command handling
  task automatic run();
    if (!linked) begin
      rptr({WAKE_SEG, 4'h0} + 20'(WUB_CCBPTR), ccb);
      rptr(ccb + 20'(CCB_CIBPTR), cib);
      cib = cib - 20'd4;
      linked = 1'b1;
      xf(1'b1, ccb + 20'(CCB_BUSY), BUSY_CLR);
    end else begin
      xf(1'b1, ccb + 20'(CCB_BUSY), BUSY_SET);
      rptr(cib + 20'(CIB_PBPTR), pba);
      for (int i = 0; i < 30; i++) begin
        xf(1'b0, pba + 20'(i), 8'h00);
        pb[i] = rd;
      end
      p = {pb[21], pb[20], 4'h0} + {4'h0, pb[19], pb[18]};
      for (int i = 0; i < int'(pb[22]); i++) xf(1'b1, p + 20'(i), 8'hc0 + 8'(i));
      for (int i = 0; i < 4; i++) xf(1'b1, pba + 20'(4 + i), pb[22 + i]);
      xf(1'b0, cib + 20'(CIB_SEM), 8'h00);
      if (rd == SEM_FREE) begin
        xf(1'b1, cib + 20'(CIB_STAT), OP_STATUS);
        xf(1'b1, cib + 20'(CIB_SEM), SEM_POSTED);
      end
      xf(1'b1, ccb + 20'(CCB_BUSY), BUSY_CLR);
      dev_int <= 1'b1;
    end
  endtask : run
  // two low bits; starts while busy are missed
  always begin
    @(posedge clk);
    if (wake_wr) begin
      case (wake_data[1:0])
        2'b00: dev_int <= 1'b0;
        2'b01: run();
        2'b10: linked = 1'b0;
        default: ;
      endcase
    end
  end
endmodule : hcbce_board

/* dv/tb_hcbce_host.sv */
// self-checking bench: init, one command per device code, a refusal
`timescale 1ns/1ps
module tb_hcbce_host
  import hcbce_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [9:0] sw_addr = '0;
  logic [31:0] sw_wdata = '0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [31:0] sw_rdata, d;
  logic wake_wr, dev_int, mem_req, mem_we, mem_ack;
  logic [7:0] wake_data, mem_wdata, mem_rdata;
  logic [19:0] mem_addr;
  logic [15:0] devs [4] = '{DEV_HARD, DEV_FLOP8, DEV_FLOP5, DEV_TAPE};
  int fail_count = 0;
  int checks = 0;
  always #4 clk = ~clk;
  hcbce_host u_hcbce_host(.SYS_CLK(clk), .RESETN(resetn), .SW_ADDR(sw_addr), .SW_WDATA(sw_wdata),
    .SW_WR(sw_wr), .SW_RD(sw_rd), .SW_RDATA(sw_rdata), .WAKE_WR(wake_wr), .WAKE_DATA(wake_data),
    .DEV_INT(dev_int), .MEM_REQ(mem_req), .MEM_WE(mem_we), .MEM_ADDR(mem_addr),
    .MEM_WDATA(mem_wdata), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata));
  hcbce_board u_hcbce_board(.clk(clk), .wake_wr(wake_wr), .wake_data(wake_data), .dev_int(dev_int),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // ==========================================
  // access tasks
  task automatic wr(input logic [9:0] a, input logic [31:0] v);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [9:0] a);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    @(posedge clk);
    d = sw_rdata;
  endtask : rd
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic cw(input logic [7:0] off, input logic [7:0] e);
    rd({2'b01, off});
    chk("window", {24'h0, e}, d);
  endtask : cw
  // bounded poll of one status bit
  task automatic waitbit(input int b);
    for (int i = 0; i < 1000 && d[b] !== 1'b1; i++) rd(REG_CTRL);
    chk("wait", 32'h1, {31'h0, d[b]});
  endtask : waitbit
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  // ==========================================
  // tests
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(REG_CTRL);
    chk("ctrl", 32'h0, d);
    wr(REG_CTRL, 32'h1 << CTRL_INIT);
    waitbit(1);
    cw(WUB_OFF, SYSOP_CODE);
    cw(CCB_OFF, PROG_ROM);
    cw(CCB_OFF + CCB_BUSY, BUSY_CLR);
    cw(CCB_OFF + CCB_CIBPTR, CIB_OFF + 8'h04);
    cw(CCB_OFF + CCB_WORD2, WORD2_CODE);
    cw(CCB_OFF + CCB_CP, CP_VAL[7:0]);
    cw(PB_OFF, 8'h00);
    $display("init test done");
    for (int k = 0; k < 4; k++) begin
      wr(REG_CMD, {devs[k], 6'h3f, 2'(k), 8'h04});
      wr(REG_REQ, 32'h4);
      wr(REG_BUF, 32'h60 + 32'(4 * k));
      wr(REG_CTRL, 32'h1 << CTRL_START);
      waitbit(2);
      rd(REG_RES);
      chk("status", {16'h0, SEM_POSTED, 8'h01}, d);
      rd(REG_ACT);
      chk("count", 32'h4, d);
      cw(CIB_OFF + CIB_SEM, SEM_FREE);
      cw(PB_OFF + PB_DEV, devs[k][7:0]);
      cw(PB_OFF + PB_UNIT, 8'(k));
      cw(8'h63 + 8'(4 * k), 8'hc3);
      wr(REG_CTRL, 32'h1 << CTRL_DONE_CLR);
      rd(REG_CTRL);
      chk("ctrl", 32'h2, d & 32'h1f);
      $display("command test %0d done", k);
    end
    wr(REG_CMD, 32'h0002_0004);
    wr(REG_CTRL, 32'h1 << CTRL_START);
    rd(REG_CTRL);
    chk("refused", 32'h12, d & 32'h1f);
    $display("refusal test done");
    end_of_test();
  end
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end
endmodule : tb_hcbce_host
